// >>> design/lpsc_pin_ctrl.sv
`timescale 1ns/10ps
module lpsc_pin_ctrl #(
	parameter int               NPINS         = 8,
	parameter logic [NPINS-1:0] MODE_GRP_MASK = '0
) (
	// clock and reset
	input  wire logic               clock,
	input  wire logic               rst,
	// apb slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// pads
	input  wire logic               externalResetN,
	input  wire logic [NPINS-1:0]   pinIn,
	output logic      [NPINS-1:0]   pinOut,
	output logic      [NPINS-1:0]   pinOeN,
	// internal input paths
	output logic      [NPINS-1:0]   pinInVal,
	output logic      [NPINS-1:0]   pinInEn,
	output logic      [NPINS-1:0]   wakeupInput,
	// oscillators and sub clock pins
	output logic                    mainOscEn,
	output logic                    subOscEn,
	output logic                    subXinInEn,
	output logic                    subXoutOeN,
	output logic                    subXoutInEn,
	output logic                    subExtOeN,
	output logic                    subExtInEn
);
	import lpsc_pkg::*;

	typedef enum logic [1:0] {RS_HOLD, RS_INT, RS_READY} lpsc_rst_t;

	logic [NPINS-1:0] pinSync1_reg, pinSync2_reg;
	logic             rstnSync1_reg, rstnSync2_reg;
	lpsc_rst_t        rsState_reg, rsState_next;
	logic [7:0]       rsCnt_reg, rsCnt_next;
	logic             ready;

	// external pins are asynchronous to clock
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pinSync1_reg  <= '0;
			pinSync2_reg  <= '0;
			rstnSync1_reg <= 1'b0;
			rstnSync2_reg <= 1'b0;
		end else begin
			pinSync1_reg  <= pinIn;
			pinSync2_reg  <= pinSync1_reg;
			rstnSync1_reg <= externalResetN;
			rstnSync2_reg <= rstnSync1_reg;
		end
	end

	always_comb begin
		rsState_next = rsState_reg;
		rsCnt_next   = rsCnt_reg;
		if (!rstnSync2_reg) begin
			rsState_next = RS_HOLD;
			rsCnt_next   = '0;
		end else begin
			case (rsState_reg)
				RS_HOLD: begin
					rsState_next = RS_INT;
				end
				RS_INT: begin
					rsCnt_next = rsCnt_reg + 8'h01;
					if (rsCnt_reg == 8'(INT_RST_CYC - 1))
						rsState_next = RS_READY;
				end
				RS_READY: begin
					rsState_next = RS_READY;
				end
				default: begin
					rsState_next = RS_HOLD;
				end
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rsState_reg <= RS_HOLD;
			rsCnt_reg   <= '0;
		end else begin
			rsState_reg <= rsState_next;
			rsCnt_reg   <= rsCnt_next;
		end
	end

	assign ready = (rsState_reg == RS_READY);

	// register file
	lpsc_mode_t         mode_reg, mode_next;
	logic               spl_reg, spl_next;
	logic [1:0]         subSel_reg, subSel_next;
	logic [2*NPINS-1:0] func_reg, func_next;
	logic [NPINS-1:0]   dout_reg, dout_next, doe_reg, doe_next;
	logic [NPINS-1:0]   wken_reg, wken_next;
	logic               dsRet_reg, dsRet_next;
	logic               apbDone, wrCtrl, newIsDs;
	logic [3:0]         wrMode;
	lpsc_mode_t         modeSel;
	logic               isDs, isTimer, isLowPower, mainRun, subRun;

	assign isDs    = (mode_reg == MODE_DS_RTC) || (mode_reg == MODE_DS_STOP);
	assign isTimer = (mode_reg == MODE_MAIN_TIMER) ||
		(mode_reg == MODE_SUB_TIMER) || (mode_reg == MODE_LCR_TIMER);
	assign isLowPower = isTimer || (mode_reg == MODE_RTC) ||
		(mode_reg == MODE_STOP);
	// main oscillator only in main-clock run, sleep and timer
	assign mainRun = (mode_reg == MODE_RUN) || (mode_reg == MODE_SLEEP) ||
		(mode_reg == MODE_MAIN_TIMER);
	// sub oscillator stops only in stop and deep-standby stop
	assign subRun = (mode_reg != MODE_STOP) && (mode_reg != MODE_DS_STOP);

	assign apbDone = psel && penable && pready;
	assign wrCtrl  = apbDone && pwrite && (paddr == ADDR_CTRL);
	assign wrMode  = pwdata[CTRL_MODE_LSB +: 4];
	// unknown mode codes leave the mode unchanged
	assign modeSel = (wrMode <= MODE_LAST) ? lpsc_mode_t'(wrMode) : mode_reg;
	assign newIsDs = (modeSel == MODE_DS_RTC) || (modeSel == MODE_DS_STOP);

	always_comb begin
		mode_next   = mode_reg;
		spl_next    = spl_reg;
		subSel_next = subSel_reg;
		func_next   = func_reg;
		dout_next   = dout_reg;
		doe_next    = doe_reg;
		wken_next   = wken_reg;
		dsRet_next  = dsRet_reg;
		if (wrCtrl) begin
			mode_next   = modeSel;
			spl_next    = pwdata[CTRL_SPL_BIT];
			subSel_next = pwdata[CTRL_SUB_LSB +: 2];
			if (isDs && !newIsDs) begin
				// pins hold their standby state until software reconfigures
				dsRet_next = 1'b1;
				// external sub clock falls back to gpio
				if (mode_reg == MODE_DS_STOP && subSel_next == SUB_EXT)
					subSel_next = SUB_GPIO;
			end
			// deep standby entry turns every pin into gpio
			if (newIsDs)
				func_next = '0;
		end else if (apbDone && pwrite) begin
			case (paddr)
				ADDR_FUNC: begin
					// function changes are locked out in deep standby
					if (!isDs) begin
						func_next  = pwdata[2*NPINS-1:0];
						dsRet_next = 1'b0;
					end
				end
				ADDR_DOUT: dout_next = pwdata[NPINS-1:0];
				ADDR_DOE:  doe_next  = pwdata[NPINS-1:0];
				ADDR_WKEN: wken_next = pwdata[NPINS-1:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mode_reg   <= MODE_RESET;
			spl_reg    <= SPL_RESET;
			subSel_reg <= SUBSEL_RESET;
			func_reg   <= '0;
			dout_reg   <= '0;
			doe_reg    <= '0;
			wken_reg   <= '0;
			dsRet_reg  <= 1'b0;
		end else begin
			mode_reg   <= mode_next;
			spl_reg    <= spl_next;
			subSel_reg <= subSel_next;
			func_reg   <= func_next;
			dout_reg   <= dout_next;
			doe_reg    <= doe_next;
			wken_reg   <= wken_next;
			dsRet_reg  <= dsRet_next;
		end
	end

	// apb answer: no wait state, pready raised in the access phase
	logic [31:0] prdata_next;
	logic        pready_next, pslverr_next, mapped;

	always_comb begin
		prdata_next = '0;
		mapped      = 1'b1;
		case (paddr)
			ADDR_CTRL: begin
				prdata_next[CTRL_SPL_BIT]       = spl_reg;
				prdata_next[CTRL_SUB_LSB +: 2]  = subSel_reg;
				prdata_next[CTRL_MODE_LSB +: 4] = mode_reg;
			end
			ADDR_FUNC:   prdata_next[2*NPINS-1:0] = func_reg;
			ADDR_DOUT:   prdata_next[NPINS-1:0]   = dout_reg;
			ADDR_DOE:    prdata_next[NPINS-1:0]   = doe_reg;
			ADDR_WKEN:   prdata_next[NPINS-1:0]   = wken_reg;
			ADDR_PINS:   prdata_next[NPINS-1:0]   = pinSync2_reg;
			ADDR_STATUS: begin
				prdata_next[ST_READY_BIT] = ready;
				prdata_next[ST_DSRET_BIT] = dsRet_reg;
				prdata_next[ST_MAIN_BIT]  = mainOscEn;
				prdata_next[ST_SUB_BIT]   = subOscEn;
			end
			default: mapped = 1'b0;
		endcase
		pready_next  = psel && !penable;
		pslverr_next = psel && !penable && !mapped;
		if (!(psel && !penable && !pwrite))
			prdata_next = prdata;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata  <= prdata_next;
			pready  <= pready_next;
			pslverr <= pslverr_next;
		end
	end

	// pad control
	logic [NPINS-1:0] out_next, oeN_next, inEn_next, wake_next;
	logic [NPINS-1:0] heldOut_reg, heldOut_next, heldOe_reg, heldOe_next;
	logic [1:0]       fn;
	logic             holdIt, hiZ;

	always_comb begin
		for (int i = 0; i < NPINS; i++) begin
			fn           = func_reg[2*i +: 2];
			holdIt       = 1'b0;
			hiZ          = 1'b0;
			inEn_next[i] = 1'b1;
			wake_next[i] = 1'b0;
			if (!ready) begin
				// floating with input enabled through reset
				hiZ = 1'b1;
			end else if (isLowPower) begin
				if (fn == FN_EXTINT) begin
					holdIt = 1'b1;
				end else if (fn == FN_ANAOUT) begin
					holdIt       = isTimer;
					hiZ          = !isTimer && spl_reg;
					inEn_next[i] = isTimer;
				end else if (MODE_GRP_MASK[i]) begin
					hiZ    = spl_reg;
					holdIt = !spl_reg;
				end else begin
					hiZ          = spl_reg;
					holdIt       = !spl_reg;
					inEn_next[i] = 1'b0;
				end
			end else if (isDs) begin
				// gpio in deep standby, wake input if enabled
				hiZ          = spl_reg;
				holdIt       = !spl_reg;
				inEn_next[i] = 1'b0;
				wake_next[i] = wken_reg[i];
			end else if (dsRet_reg) begin
				holdIt = 1'b1;
			end
			if (hiZ) begin
				out_next[i] = 1'b0;
				oeN_next[i] = 1'b1;
			end else if (holdIt) begin
				out_next[i] = heldOut_reg[i];
				oeN_next[i] = !heldOe_reg[i];
			end else begin
				out_next[i] = dout_reg[i];
				oeN_next[i] = !doe_reg[i];
			end
		end
		// track the driven state, deep standby included, so a
		// return from standby keeps what the pads showed in standby
		if (ready && !isLowPower && !dsRet_reg) begin
			heldOut_next = pinOut;
			heldOe_next  = ~pinOeN;
		end else begin
			heldOut_next = heldOut_reg;
			heldOe_next  = heldOe_reg;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pinOut      <= '0;
			pinOeN      <= '1;
			pinInEn     <= '1;
			pinInVal    <= '0;
			wakeupInput <= '0;
			heldOut_reg <= '0;
			heldOe_reg  <= '0;
		end else begin
			pinOut      <= out_next;
			pinOeN      <= oeN_next;
			pinInEn     <= inEn_next;
			pinInVal    <= inEn_next & pinSync2_reg;
			wakeupInput <= wake_next;
			heldOut_reg <= heldOut_next;
			heldOe_reg  <= heldOe_next;
		end
	end

	// oscillators and sub clock pins
	logic xtal, ext, anyLp;
	assign xtal  = ready && (subSel_reg == SUB_XTAL);
	assign ext   = ready && (subSel_reg == SUB_EXT);
	assign anyLp = isLowPower || isDs;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mainOscEn   <= 1'b1;
			subOscEn    <= 1'b1;
			subXinInEn  <= 1'b1;
			subXoutOeN  <= 1'b1;
			subXoutInEn <= 1'b0;
			subExtOeN   <= 1'b1;
			subExtInEn  <= 1'b0;
		end else begin
			mainOscEn   <= mainRun;
			subOscEn    <= subRun;
			subXinInEn  <= 1'b1;
			// crystal output floats once oscillation stops
			subXoutOeN  <= !(xtal && subRun);
			subXoutInEn <= xtal && subRun;
			subExtOeN   <= ext ? (anyLp && spl_reg) || subExtOeN : 1'b1;
			subExtInEn  <= ext && subRun;
		end
	end

	chk_reset_hiz: assert property (@(posedge clock) disable iff (rst)
		!ready |=> (&pinOeN) && (&pinInEn))
		else $error("pins not floating with input on during reset");
	chk_xin_enabled: assert property (@(posedge clock) disable iff (rst)
		1'b1 |=> subXinInEn)
		else $error("sub crystal input path gated");
	chk_lp_float: assert property (@(posedge clock) disable iff (rst)
		ready && isLowPower && spl_reg && func_reg[1:0] == FN_GPIO &&
		!MODE_GRP_MASK[0] |=> pinOeN[0] && !pinInEn[0] && !pinInVal[0])
		else $error("gpio not floated in low power");
	chk_lp_hold: assert property (@(posedge clock) disable iff (rst)
		ready && isLowPower && !spl_reg && func_reg[1:0] == FN_GPIO
		|=> pinOut[0] == $past(heldOut_reg[0]) &&
		pinOeN[0] == !$past(heldOe_reg[0]) && !pinInEn[0])
		else $error("gpio level not held in low power");
	chk_ds_gpio: assert property (@(posedge clock) disable iff (rst)
		isDs |-> func_reg == '0)
		else $error("peripheral function left in deep standby");
	chk_ret_hold: assert property (@(posedge clock) disable iff (rst)
		ready && dsRet_reg && !isLowPower && !isDs
		|=> pinOut == $past(heldOut_reg))
		else $error("held state lost after deep standby");
	chk_extint_hold: assert property (@(posedge clock) disable iff (rst)
		ready && isLowPower && func_reg[1:0] == FN_EXTINT
		|=> pinInEn[0] && pinOut[0] == $past(heldOut_reg[0]))
		else $error("interrupt pin not kept in low power");
	chk_main_osc: assert property (@(posedge clock) disable iff (rst)
		(mode_reg == MODE_SUB_RUN || mode_reg == MODE_RTC ||
		mode_reg == MODE_STOP || isDs) ##1 1'b1 |-> !mainOscEn)
		else $error("main oscillator running in a low mode");
	chk_sub_osc: assert property (@(posedge clock) disable iff (rst)
		1'b1 |=> subOscEn == ($past(mode_reg) != MODE_STOP &&
		$past(mode_reg) != MODE_DS_STOP))
		else $error("sub oscillator enable wrong for mode");
endmodule

// >>> shared/lpsc_pkg.sv
package lpsc_pkg;
	// register byte offsets
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_FUNC   = 8'h04;
	localparam logic [7:0] ADDR_DOUT   = 8'h08;
	localparam logic [7:0] ADDR_DOE    = 8'h0c;
	localparam logic [7:0] ADDR_WKEN   = 8'h10;
	localparam logic [7:0] ADDR_PINS   = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	// ctrl field positions
	localparam int CTRL_SPL_BIT  = 0;
	localparam int CTRL_SUB_LSB  = 4;
	localparam int CTRL_MODE_LSB = 8;
	// status field positions
	localparam int ST_READY_BIT = 0;
	localparam int ST_DSRET_BIT = 1;
	localparam int ST_MAIN_BIT  = 2;
	localparam int ST_SUB_BIT   = 3;
	// pin function codes
	localparam logic [1:0] FN_GPIO   = 2'h0;
	localparam logic [1:0] FN_PERIPH = 2'h1;
	localparam logic [1:0] FN_EXTINT = 2'h2;
	localparam logic [1:0] FN_ANAOUT = 2'h3;
	// sub clock pin selection
	localparam logic [1:0] SUB_XTAL = 2'h0;
	localparam logic [1:0] SUB_EXT  = 2'h1;
	localparam logic [1:0] SUB_GPIO = 2'h2;
	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int INT_RST_NS    = 1000;
	localparam int INT_RST_CYC   =
		(INT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [3:0] {
		MODE_RUN, MODE_SLEEP, MODE_SUB_RUN, MODE_LCR_RUN,
		MODE_SUB_SLEEP, MODE_LCR_SLEEP, MODE_MAIN_TIMER,
		MODE_SUB_TIMER, MODE_LCR_TIMER, MODE_RTC, MODE_STOP,
		MODE_DS_RTC, MODE_DS_STOP
	} lpsc_mode_t;
	localparam logic [3:0] MODE_LAST = 4'hc;
	// reset values
	localparam lpsc_mode_t MODE_RESET   = MODE_RUN;
	localparam logic [1:0] SUBSEL_RESET = SUB_XTAL;
	localparam logic       SPL_RESET    = 1'b0;
endpackage

// >>> verif/lpsc_board_model.sv
`timescale 1ns/10ps
module lpsc_board_model (
	// pads as the board sees them
	input  wire logic [7:0] pinOut,
	input  wire logic [7:0] pinOeN,
	input  wire logic [7:0] boardLevel,
	// level returned to the pad inputs
	output logic      [7:0] pinIn
);
	// a released pad settles to the board's own pull level, never the last
	// driven value, so a stale hold cannot pass for a live one
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pinIn[i] = pinOeN[i] ? boardLevel[i] : pinOut[i];
		end
	end
endmodule

// >>> verif/tb_low_power_pin_state_control.sv
`timescale 1ns/10ps
module tb_low_power_pin_state_control;
	import lpsc_pkg::*;
	logic        clock, rst, psel, penable, pwrite, externalResetN;
	logic [7:0]  paddr, pinIn, pinOut, pinOeN, pinInVal, pinInEn;
	logic [7:0]  wakeupInput, boardLevel;
	logic [31:0] pwdata, prdata, rdData;
	logic        pready, pslverr, rdErr, eMain, eSub;
	logic        mainOscEn, subOscEn, subXinInEn, subXoutOeN;
	logic        subXoutInEn, subExtOeN, subExtInEn;
	int          errors, n_tests, n, m;

	lpsc_pin_ctrl #(.NPINS(8), .MODE_GRP_MASK(8'h80)) u_dut (
		.clock(clock), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr),
		.externalResetN(externalResetN), .pinIn(pinIn),
		.pinOut(pinOut), .pinOeN(pinOeN), .pinInVal(pinInVal),
		.pinInEn(pinInEn), .wakeupInput(wakeupInput),
		.mainOscEn(mainOscEn), .subOscEn(subOscEn),
		.subXinInEn(subXinInEn), .subXoutOeN(subXoutOeN),
		.subXoutInEn(subXoutInEn), .subExtOeN(subExtOeN),
		.subExtInEn(subExtInEn));

	lpsc_board_model u_board (.pinOut(pinOut), .pinOeN(pinOeN),
		.boardLevel(boardLevel), .pinIn(pinIn));

	always #50 clock = ~clock;

	task automatic complete_run;
		$display("errors %0d n_tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: %s seen %h want %h",
				$time, what, seen, exp);
		end
	endtask

	// one apb transfer; waits for pready with a bounded count
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		@(posedge clock);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clock);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rdData = prdata;
		rdErr  = pslverr;
		if (k >= 50) begin
			chk(0, 1, "pready timeout");
		end
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		repeat (5) @(posedge clock);
		// look between edges, where registered outputs have settled
		@(negedge clock);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp,
		input string what);
		apb(1'b0, a, 32'h0);
		chk(rdData, exp, what);
	endtask

	task automatic ctrl(input logic [3:0] md, input logic [1:0] sub,
		input logic standby_pin_level_select);
		wr(ADDR_CTRL, {20'h0, md, 2'h0, sub, 3'h0, standby_pin_level_select});
	endtask

	initial begin
		#2000000;
		errors++;
		complete_run;
	end

	initial begin
		clock = 0;
		rst = 1;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 8'h00;
		pwdata = 32'h0;
		externalResetN = 0;
		boardLevel = 8'h3c;
		errors = 0;
		n_tests = 0;
		repeat (6) @(posedge clock);
		chk(pinOeN, 8'hff, "oe in reset");
		chk(pinInEn, 8'hff, "inen in reset");
		chk(subXinInEn, 1'b1, "xin in reset");
		rst <= 1'b0;
		repeat (4) @(posedge clock);
		chk(pinOeN, 8'hff, "oe ext reset");
		chk(pinInEn, 8'hff, "inen ext reset");
		externalResetN <= 1'b1;
		n = 0;
		do begin
			apb(1'b0, ADDR_STATUS, 32'h0);
			n++;
		end while (rdData[ST_READY_BIT] !== 1'b1 && n < 40);
		chk(rdData[ST_READY_BIT], 1'b1, "ready");
		apb(1'b0, 8'h1c, 32'h0);
		chk(rdErr, 1'b1, "unmapped err");
		chk(rdData, 32'h0, "unmapped data");
		// low nibble driven, high nibble floats to the board level
		wr(ADDR_DOE, 32'h0f);
		wr(ADDR_DOUT, 32'ha5);
		chk(pinInVal, 8'h35, "input path run");
		rd(ADDR_PINS, 32'h35, "pins reg");
		wr(ADDR_DOE, 32'hff);
		wr(ADDR_FUNC, 32'h0e);
		ctrl(MODE_STOP, SUB_XTAL, 1'b0);
		chk(pinOeN, 8'h00, "stop spl0 oe");
		chk(pinInEn & 8'h7e, 8'h00, "stop spl0 inen");
		chk(pinInVal & 8'h7e, 8'h00, "stop spl0 inval");
		wr(ADDR_DOUT, 32'h00);
		chk(pinOut, 8'ha5, "held level");
		chk({mainOscEn, subOscEn}, 2'b00, "osc stop");
		chk({subXoutOeN, subXoutInEn}, 2'b10, "xout stop");
		chk(subXinInEn, 1'b1, "xin stop");
		ctrl(MODE_RUN, SUB_XTAL, 1'b0);
		wr(ADDR_DOUT, 32'ha5);
		ctrl(MODE_STOP, SUB_XTAL, 1'b1);
		chk(pinOeN, 8'hfe, "stop spl1 oe");
		chk(pinInEn & 8'hfe, 8'h80, "stop spl1 inen");
		chk(pinOut[0], 1'b1, "extint held");
		ctrl(MODE_MAIN_TIMER, SUB_XTAL, 1'b1);
		chk(pinOeN, 8'hfc, "timer spl1 oe");
		ctrl(MODE_RTC, SUB_XTAL, 1'b1);
		chk(pinOeN, 8'hfe, "rtc spl1 oe");
		chk({mainOscEn, subOscEn}, 2'b01, "osc rtc");
		chk(subXoutOeN, 1'b0, "xout rtc");
		ctrl(MODE_RUN, SUB_XTAL, 1'b0);
		for (m = 0; m <= 12; m++) begin
			eMain = !(m inside {[2:5], [7:12]});
			eSub  = !(m == 10 || m == 12);
			ctrl(m[3:0], SUB_XTAL, 1'b0);
			chk({mainOscEn, subOscEn}, {eMain, eSub}, "osc table");
			chk(subXinInEn, 1'b1, "xin table");
		end
		ctrl(4'hd, SUB_XTAL, 1'b0);
		chk(subOscEn, 1'b0, "bad mode kept");
		ctrl(MODE_RUN, SUB_XTAL, 1'b0);
		wr(ADDR_FUNC, 32'h00);
		ctrl(MODE_RTC, SUB_EXT, 1'b1);
		chk({subExtOeN, subExtInEn}, 2'b11, "ext rtc spl1");
		ctrl(MODE_STOP, SUB_EXT, 1'b1);
		chk({subExtOeN, subExtInEn}, 2'b10, "ext stop spl1");
		ctrl(MODE_STOP, SUB_EXT, 1'b0);
		chk(subExtInEn, 1'b0, "ext stop spl0");
		ctrl(MODE_RUN, SUB_XTAL, 1'b1);
		wr(ADDR_FUNC, 32'h10);
		wr(ADDR_WKEN, 32'h08);
		ctrl(MODE_DS_RTC, SUB_XTAL, 1'b1);
		rd(ADDR_FUNC, 32'h0, "func cleared");
		chk(pinInEn[2], 1'b0, "periph inen");
		chk(wakeupInput, 8'h08, "wake input");
		chk(pinOeN[3], 1'b1, "wake pin hiz");
		wr(ADDR_FUNC, 32'h01);
		rd(ADDR_FUNC, 32'h0, "func locked");
		wr(ADDR_DOUT, 32'h0f);
		ctrl(MODE_RUN, SUB_XTAL, 1'b1);
		rd(ADDR_STATUS, 32'h0f, "return flag");
		chk({pinOut, pinOeN}, 16'h00ff, "held after ds");
		wr(ADDR_FUNC, 32'h00);
		chk(pinOut, 8'h0f, "released");
		rd(ADDR_STATUS, 32'h0d, "flag cleared");
		ctrl(MODE_DS_STOP, SUB_EXT, 1'b0);
		ctrl(MODE_RUN, SUB_EXT, 1'b0);
		rd(ADDR_CTRL, 32'h20, "ext sub clock to gpio");
		complete_run;
	end
endmodule
